// file: src/serial_port_pkg.sv
// Notes on behaviour
// - default bit rate is 115200 b/s after initialisation
// - frames are eight data bits, no parity, one stop bit
// - low line is zero data or control ON, high is one or OFF
// - main port: drive rx data, set-ready, carrier, ring; sample tx data, terminal-ready
// - clear-to-send is our flow output; request-to-send gates our sending on the main port only
// - unsolicited reports go out only if terminal-ready is low when written, main port only
// - serial port is command path only when usb path is not enabled
// - usb path chosen only if bus voltage valid when boot completes and held
// - after boot, port is initialised and enabled if usb path is off
// - in command mode every received character is a command character
// - bit rate is configurable and applies to following frames
// - no automatic rate or format detection
// - aux port: carrier out data, terminal-ready in data, ring flow out, set-ready held OFF
// - status lines are modem lines or aux port, never both
// - main port may carry a multiplexer with hdlc-style framing; CTRL_MUX_EN is only stored, no mux or framing is built
// - mux channels: 0 control, 1 commands, 2 dial-up, 3 positioning
`default_nettype none
package serial_port_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DEFAULT_BAUD = 115_200;
  // rounded to nearest count of clocks per bit
  localparam logic [15:0] DEFAULT_DIV = 16'((CLK_HZ + DEFAULT_BAUD / 2) / DEFAULT_BAUD);
  localparam int unsigned DATA_BITS = 8;
  localparam logic [11:0] ADDR_DIV = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_TXDATA = 12'h00c;
  localparam logic [11:0] ADDR_RXDATA = 12'h010;
  localparam logic [11:0] ADDR_MODEM = 12'h014;
  localparam int unsigned CTRL_AUX_SEL = 0;
  localparam int unsigned CTRL_MUX_EN = 1;
  localparam int unsigned CTRL_FLOW_EN = 2;
  localparam int unsigned CTRL_REPORT = 3;
  localparam int unsigned CTRL_DATA_MODE = 4;
  localparam logic [4:0] CTRL_RESET = 5'h04;
  localparam int unsigned MODEM_DSR = 0;
  localparam int unsigned MODEM_DCD = 1;
  localparam int unsigned MODEM_RI = 2;
  localparam logic [2:0] MODEM_RESET = 3'h0;
  localparam logic [1:0] CH_MUX_CTRL = 2'h0;
  localparam logic [1:0] CH_COMMAND = 2'h1;
  localparam logic [1:0] CH_DIAL_UP = 2'h2;
  localparam logic [1:0] CH_POSITION = 2'h3;
  localparam logic [7:0] HDLC_FLAG = 8'hf9;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage
`default_nettype wire

// file: src/serial_port.sv
`default_nettype none
module serial_port
  import serial_port_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HSEL,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_USB_BUS_VOLTAGE_SENSE,
  input wire logic I_BOOT_DONE,
  input wire logic I_TXD,
  input wire logic I_RTS_N,
  input wire logic I_DTR_N,
  output logic O_RXD,
  output logic O_CTS_N,
  output logic O_DSR_N,
  output logic O_DCD_N,
  output logic O_RI_N,
  output logic O_PORT_ENABLED,
  output logic O_USB_SELECTED
);
  timeunit 1ns;
  timeprecision 1ns;
  // 2-flop synchronisers for pins
  logic [4:0] s1_q, s2_q;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      // idle pin levels: sense and boot low, serial and control lines OFF
      s1_q <= 5'h0e;
      s2_q <= 5'h0e;
    end else begin
      s1_q <= {I_USB_BUS_VOLTAGE_SENSE, I_TXD, I_RTS_N, I_DTR_N, I_BOOT_DONE};
      s2_q <= s1_q;
    end
  end
  logic vbus_s, txd_s, rts_n_s, dtr_n_s, boot_s;
  assign {vbus_s, txd_s, rts_n_s, dtr_n_s, boot_s} = s2_q;

  // boot / path selection
  logic booted_q, booted_d, usb_q, usb_d, vbus_seen_q, vbus_seen_d;
  always_comb begin
    vbus_seen_d = vbus_seen_q;
    booted_d = booted_q | boot_s;
    usb_d = usb_q;
    if (!booted_q) begin
      vbus_seen_d = vbus_s;
      usb_d = vbus_s;
    end else if (!vbus_s) begin
      usb_d = 1'b0;
    end
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      booted_q <= 1'b0;
      usb_q <= 1'b0;
      vbus_seen_q <= 1'b0;
    end else begin
      booted_q <= booted_d;
      usb_q <= usb_d;
      vbus_seen_q <= vbus_seen_d;
    end
  end
  // usb path keeps the port off even if the sense drops later
  logic port_en;
  assign port_en = booted_q & ~vbus_seen_q;

  // registers
  logic [15:0] div_q, div_d;
  logic [4:0] ctrl_q, ctrl_d;
  logic [2:0] modem_q, modem_d;
  logic [7:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
  logic txfull_q, txfull_d, rxfull_q, rxfull_d, ovr_q, ovr_d, frerr_q, frerr_d;
  logic [1:0] txch_q, txch_d;
  logic [31:0] rdata_q, rdata_d;
  logic [11:0] a_q, a_d;
  logic wr_q, wr_d, rd_q, rd_d;
  logic aux;
  assign aux = ctrl_q[CTRL_AUX_SEL];

  // serial engines
  tx_state_t ts_q, ts_d;
  rx_state_t rs_q, rs_d;
  logic [15:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
  logic [2:0] tbit_q, tbit_d, rbit_q, rbit_d;
  logic [7:0] tsh_q, tsh_d, rsh_q, rsh_d;
  logic line_q, line_d;
  logic rx_done, rx_ok;
  logic rx_in, flow_in_n, tx_go;
  // aux port swaps data and flow onto status lines
  assign rx_in = aux ? dtr_n_s : txd_s;
  assign flow_in_n = aux ? dtr_n_s : rts_n_s;
  // host flow input gates sending on the main port only; there it must be held ON even without flow control
  assign tx_go = txfull_q & port_en & (aux ? 1'b1 : ~rts_n_s);

  function automatic logic [15:0] half(input logic [15:0] d);
    half = {1'b0, d[15:1]};
  endfunction

  always_comb begin
    ts_d = ts_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    tsh_d = tsh_q;
    line_d = line_q;
    unique case (ts_q)
      TX_IDLE: begin
        line_d = 1'b1;
        if (tx_go) begin
          ts_d = TX_START;
          tsh_d = txbuf_q;
          tcnt_d = div_q;
          line_d = 1'b0;
        end
      end
      TX_START, TX_DATA: begin
        if (tcnt_q <= 16'h0001) begin
          tcnt_d = div_q;
          if (ts_q == TX_START) begin
            ts_d = TX_DATA;
            tbit_d = 3'h0;
            line_d = tsh_q[0];
          end else if (tbit_q == 3'(DATA_BITS - 1)) begin
            ts_d = TX_STOP;
            line_d = 1'b1;
          end else begin
            tbit_d = tbit_q + 3'h1;
            tsh_d = {1'b0, tsh_q[7:1]};
            line_d = tsh_q[1];
          end
        end else begin
          tcnt_d = tcnt_q - 16'h0001;
        end
      end
      TX_STOP: begin
        if (tcnt_q <= 16'h0001) begin
          ts_d = TX_IDLE;
        end else begin
          tcnt_d = tcnt_q - 16'h0001;
        end
      end
    endcase
  end

  always_comb begin
    rs_d = rs_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    rx_done = 1'b0;
    rx_ok = 1'b0;
    unique case (rs_q)
      RX_IDLE: begin
        if (port_en && !rx_in) begin
          rs_d = RX_START;
          rcnt_d = half(div_q);
        end
      end
      RX_START: begin
        if (rcnt_q <= 16'h0001) begin
          rcnt_d = div_q;
          rbit_d = 3'h0;
          rs_d = rx_in ? RX_IDLE : RX_DATA;
        end else begin
          rcnt_d = rcnt_q - 16'h0001;
        end
      end
      RX_DATA: begin
        if (rcnt_q <= 16'h0001) begin
          rcnt_d = div_q;
          rsh_d = {rx_in, rsh_q[7:1]};
          if (rbit_q == 3'(DATA_BITS - 1)) begin
            rs_d = RX_STOP;
          end else begin
            rbit_d = rbit_q + 3'h1;
          end
        end else begin
          rcnt_d = rcnt_q - 16'h0001;
        end
      end
      RX_STOP: begin
        if (rcnt_q <= 16'h0001) begin
          rs_d = RX_IDLE;
          rx_done = 1'b1;
          rx_ok = rx_in;
        end else begin
          rcnt_d = rcnt_q - 16'h0001;
        end
      end
    endcase
  end

  // bus and register next state
  logic take;
  assign take = I_HSEL & I_HREADY & I_HTRANS[1];
  always_comb begin
    div_d = div_q;
    ctrl_d = ctrl_q;
    modem_d = modem_q;
    txbuf_d = txbuf_q;
    txch_d = txch_q;
    rxbuf_d = rxbuf_q;
    txfull_d = txfull_q & ~(ts_q == TX_IDLE && tx_go);
    rxfull_d = rxfull_q;
    ovr_d = ovr_q;
    frerr_d = frerr_q;
    a_d = take ? I_HADDR[11:0] : a_q;
    wr_d = take & I_HWRITE;
    rd_d = take & ~I_HWRITE;
    rdata_d = 32'h0;
    if (wr_q) begin
      unique case (a_q)
        ADDR_DIV: begin
          if (I_HWDATA[15:0] >= 16'h0002) begin
            div_d = I_HWDATA[15:0];
          end
        end
        ADDR_CTRL: ctrl_d = I_HWDATA[4:0];
        ADDR_TXDATA: begin
          if (!txfull_q) begin
            txbuf_d = I_HWDATA[7:0];
            txch_d = I_HWDATA[9:8];
            // reports dropped if written on the main port while terminal-ready is OFF
            if (!(I_HWDATA[10] && ctrl_q[CTRL_REPORT] && dtr_n_s && !aux)) begin
              txfull_d = 1'b1;
            end
          end
        end
        ADDR_MODEM: modem_d = I_HWDATA[2:0];
        ADDR_STATUS: begin
          if (I_HWDATA[2]) ovr_d = 1'b0;
          if (I_HWDATA[3]) frerr_d = 1'b0;
        end
        default: ;
      endcase
    end
    if (rd_q && a_q == ADDR_RXDATA) rxfull_d = 1'b0;
    // set wins over clear
    if (rx_done) begin
      if (rx_ok) begin
        if (rxfull_q && !(rd_q && a_q == ADDR_RXDATA)) ovr_d = 1'b1;
        rxbuf_d = rsh_q;
        rxfull_d = 1'b1;
      end else begin
        frerr_d = 1'b1;
      end
    end
    if (take && !I_HWRITE) begin
      unique case (I_HADDR[11:0])
        ADDR_DIV: rdata_d = {16'h0, div_q};
        ADDR_CTRL: rdata_d = {27'h0, ctrl_q};
        ADDR_STATUS: rdata_d = {24'h0, ~dtr_n_s, ~rts_n_s, usb_q, port_en, frerr_q, ovr_q,
                                rxfull_q, txfull_q};
        ADDR_RXDATA: rdata_d = {24'h0, rxbuf_q};
        ADDR_MODEM: rdata_d = {29'h0, modem_q};
        ADDR_TXDATA: rdata_d = {22'h0, txch_q, txbuf_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_q <= DEFAULT_DIV;
      ctrl_q <= CTRL_RESET;
      modem_q <= MODEM_RESET;
      txbuf_q <= 8'h00;
      txch_q <= CH_COMMAND;
      rxbuf_q <= 8'h00;
      txfull_q <= 1'b0;
      rxfull_q <= 1'b0;
      ovr_q <= 1'b0;
      frerr_q <= 1'b0;
      rdata_q <= 32'h0;
      a_q <= 12'h000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ts_q <= TX_IDLE;
      rs_q <= RX_IDLE;
      tcnt_q <= 16'h0;
      rcnt_q <= 16'h0;
      tbit_q <= 3'h0;
      rbit_q <= 3'h0;
      tsh_q <= 8'h00;
      rsh_q <= 8'h00;
      line_q <= 1'b1;
    end else begin
      div_q <= div_d;
      ctrl_q <= ctrl_d;
      modem_q <= modem_d;
      txbuf_q <= txbuf_d;
      txch_q <= txch_d;
      rxbuf_q <= rxbuf_d;
      txfull_q <= txfull_d;
      rxfull_q <= rxfull_d;
      ovr_q <= ovr_d;
      frerr_q <= frerr_d;
      rdata_q <= rdata_d;
      a_q <= a_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      ts_q <= ts_d;
      rs_q <= rs_d;
      tcnt_q <= tcnt_d;
      rcnt_q <= rcnt_d;
      tbit_q <= tbit_d;
      rbit_q <= rbit_d;
      tsh_q <= tsh_d;
      rsh_q <= rsh_d;
      line_q <= line_d;
    end
  end

  // pin mapping, low = ON
  logic cts_n;
  assign cts_n = ~(port_en & ~rxfull_q);
  assign O_RXD = aux ? 1'b1 : line_q;
  assign O_CTS_N = cts_n;
  assign O_DCD_N = aux ? line_q : ~modem_q[MODEM_DCD];
  assign O_RI_N = aux ? cts_n : ~modem_q[MODEM_RI];
  assign O_DSR_N = ~modem_q[MODEM_DSR] | aux;
  assign O_PORT_ENABLED = port_en;
  assign O_USB_SELECTED = usb_q;
  assign O_HRDATA = rdata_q;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  logic unused;
  assign unused = ^{I_HADDR[31:12], I_HADDR[1:0], I_HSIZE, I_HWDATA[31:11], flow_in_n,
                    ctrl_q[CTRL_MUX_EN], ctrl_q[CTRL_DATA_MODE], ctrl_q[CTRL_FLOW_EN]};
endmodule
`default_nettype wire

// file: verification/serial_port_chk.sv
`default_nettype none
module serial_port_chk (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_HSEL,
  input wire logic I_HREADY,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_BOOT_DONE,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic O_RXD,
  input wire logic O_CTS_N,
  input wire logic O_PORT_ENABLED,
  input wire logic O_USB_SELECTED
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_ph_q;
  logic rd_ph_d;
  always_comb rd_ph_d = I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) rd_ph_q <= 1'b0;
    else rd_ph_q <= rd_ph_d;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence start_low;
    !O_RXD [*8];
  endsequence
  AST_BUS_OKAY: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus answer not ready or not okay");
  AST_RDATA_IDLE: assert property (!rd_ph_q |-> O_HRDATA == 32'h0)
    else $error("read data outside data phase");
  AST_EXCLUSIVE: assert property (!(O_PORT_ENABLED && O_USB_SELECTED))
    else $error("serial and usb paths both active");
  AST_USB_LOCKOUT: assert property (O_USB_SELECTED |-> O_RXD && O_CTS_N)
    else $error("serial lines active with usb path");
  AST_IDLE_HIGH: assert property (!O_PORT_ENABLED |-> O_RXD && O_CTS_N)
    else $error("lines not off while port disabled");
  AST_STAYS_ON: assert property (O_PORT_ENABLED |=> O_PORT_ENABLED)
    else $error("port dropped after enable");
  AST_ENABLE_CAUSE: assert property ($rose(O_PORT_ENABLED) |-> $past(I_BOOT_DONE))
    else $error("port enabled without boot done");
  AST_START_BIT: assert property ($fell(O_RXD) |-> start_low)
    else $error("start bit too short");
endmodule
bind serial_port serial_port_chk chk_u (.I_CLK, .I_RST_N, .I_HSEL, .I_HREADY, .I_HTRANS,
  .I_HWRITE, .I_BOOT_DONE, .O_HRDATA, .O_HREADYOUT, .O_HRESP, .O_RXD, .O_CTS_N,
  .O_PORT_ENABLED, .O_USB_SELECTED);
`default_nettype wire

// file: verification/host_terminal_model.sv
`default_nettype none
module host_terminal_model (
  input wire logic i_clk,
  input wire logic i_rxd,
  output var logic o_txd,
  output var logic o_rts_n,
  output var logic o_dtr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_txd = 1'b1;
    o_rts_n = 1'b0;
    o_dtr_n = 1'b0;
  end
  // bit period always given by caller, no auto detection
  task automatic send(input logic [7:0] b, input int div, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_txd <= f[i];
      repeat (div) @(posedge i_clk);
    end
    o_txd <= 1'b1;
  endtask
  task automatic recv(input int div, output logic [7:0] b, output logic stp);
    while (i_rxd !== 1'b0) @(posedge i_clk);
    repeat (div / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge i_clk);
      b[i] = i_rxd;
    end
    repeat (div) @(posedge i_clk);
    stp = i_rxd;
  endtask
endmodule
`default_nettype wire

// file: verification/serial_port_bench.sv
`default_nettype none
module serial_port_bench import serial_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, hwrite, sense, boot, rdy, resp, rxd, cts_n, dsr_n, dcd_n, ri_n;
  logic en, usb, txd, rts_n, dtr_n, s;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [7:0] b;
  int num_errors, checks_done;
  localparam int DV = int'(DEFAULT_DIV);
  serial_port dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HSEL(1'b1), .I_HREADY(rdy),
    .O_HRDATA(hrdata), .O_HREADYOUT(rdy), .O_HRESP(resp), .I_USB_BUS_VOLTAGE_SENSE(sense),
    .I_BOOT_DONE(boot), .I_TXD(txd), .I_RTS_N(rts_n), .I_DTR_N(dtr_n), .O_RXD(rxd),
    .O_CTS_N(cts_n), .O_DSR_N(dsr_n), .O_DCD_N(dcd_n), .O_RI_N(ri_n),
    .O_PORT_ENABLED(en), .O_USB_SELECTED(usb));
  host_terminal_model host_u (.i_clk(clk), .i_rxd(rxd), .o_txd(txd), .o_rts_n(rts_n),
    .o_dtr_n(dtr_n));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic tx_expect(input logic [7:0] e, input int div);
    host_u.recv(div, b, s);
    chk("tx byte", {24'h0, e}, {24'h0, b});
    chk("tx stop", 1, {31'h0, s});
  endtask
  task automatic t_reset();
    chk("rxd idle", 1, {31'h0, rxd});
    chk("enabled", 0, {31'h0, en});
    bus(0, ADDR_DIV, 0);
    chk("div", {16'h0, DEFAULT_DIV}, r);
    bus(0, ADDR_CTRL, 0);
    chk("ctrl", 32'h4, r);
    bus(0, 12'h020, 0);
    chk("unmapped", 0, r);
    bus(0, ADDR_TXDATA, 0);
    chk("tx channel reset", {22'h0, CH_COMMAND, 8'h00}, r);
    boot <= 1'b1;
    repeat (8) @(posedge clk);
    chk("enabled", 1, {31'h0, en});
    chk("cts on", 0, {31'h0, cts_n});
    bus(0, ADDR_STATUS, 0);
    chk("status en usb", 32'h1, {30'h0, r[5:4]});
    $display("reset test done");
  endtask
  task automatic t_link();
    bus(1, ADDR_TXDATA, 32'ha3);
    tx_expect(8'ha3, DV);
    host_u.send(8'h3c, DV, 1'b1);
    bus(0, ADDR_STATUS, 0);
    chk("rx full", 1, {31'h0, r[1]});
    bus(0, ADDR_RXDATA, 0);
    chk("rx byte", 32'h3c, {24'h0, r[7:0]});
    host_u.send(8'h0f, DV, 1'b0);
    bus(0, ADDR_STATUS, 0);
    chk("frame err", 1, {31'h0, r[3]});
    bus(1, ADDR_STATUS, 32'h8);
    bus(0, ADDR_RXDATA, 0);
    bus(0, ADDR_STATUS, 0);
    chk("err cleared", 0, {31'h0, r[3]});
    $display("link test done");
  endtask
  task automatic t_gate();
    host_u.o_rts_n <= 1'b1;
    bus(1, ADDR_TXDATA, 32'h5a);
    repeat (300) @(posedge clk);
    chk("held by rts", 1, {31'h0, rxd});
    host_u.o_rts_n <= 1'b0;
    tx_expect(8'h5a, DV);
    bus(1, ADDR_CTRL, 32'h0c);
    host_u.o_dtr_n <= 1'b1;
    // terminal-ready passes the pin synchroniser first
    repeat (3) @(posedge clk);
    bus(1, ADDR_TXDATA, 32'h441);
    repeat (300) @(posedge clk);
    chk("report dropped", 1, {31'h0, rxd});
    host_u.o_dtr_n <= 1'b0;
    repeat (3) @(posedge clk);
    bus(1, ADDR_TXDATA, 32'h441);
    tx_expect(8'h41, DV);
    bus(1, ADDR_CTRL, 32'h04);
    $display("gate test done");
  endtask
  task automatic t_rate();
    bus(1, ADDR_DIV, 32'h1);
    bus(0, ADDR_DIV, 0);
    chk("div refused", {16'h0, DEFAULT_DIV}, r);
    bus(1, ADDR_DIV, 32'h28);
    bus(1, ADDR_TXDATA, 32'h2c6);
    bus(0, ADDR_TXDATA, 0);
    chk("tx channel", {22'h0, CH_DIAL_UP, 8'hc6}, r);
    tx_expect(8'hc6, 40);
    host_u.send(8'h81, 40, 1'b1);
    bus(0, ADDR_RXDATA, 0);
    chk("rx new rate", 32'h81, {24'h0, r[7:0]});
    bus(1, ADDR_MODEM, 32'h5);
    // the write lands at the closing edge of the data phase
    @(posedge clk);
    chk("modem lines", 32'h2, {29'h0, dsr_n, dcd_n, ri_n});
    bus(1, ADDR_CTRL, 32'h05);
    @(posedge clk);
    chk("aux lines", 32'h6, {29'h0, dsr_n, dcd_n, ri_n});
    $display("rate test done");
  endtask
  task automatic t_usb();
    rst_n <= 1'b0;
    sense <= 1'b1;
    boot <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    boot <= 1'b1;
    repeat (8) @(posedge clk);
    chk("usb", 1, {31'h0, usb});
    chk("port off", 0, {31'h0, en});
    $display("usb test done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial begin
    {rst_n, hwrite, sense, boot, haddr, hwdata, htrans} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_link();
    t_gate();
    t_rate();
    t_usb();
    conclude();
  end
endmodule
`default_nettype wire
